/* tpv_pkg.sv */
// Package for the tap position decoder and first voltage window block
package tpv_pkg;

  // Position source selection
  typedef enum logic [1:0] {
    TPV_SRC_BIN    = 2'h0,
    TPV_SRC_BCD    = 2'h1,
    TPV_SRC_RES    = 2'h2,
    TPV_SRC_DIVOLT = 2'h3
  } tpv_src_t;

  // Window state, Gray coded along inside -> timing -> fire
  typedef enum logic [1:0] {
    TPV_ST_IN   = 2'b00,
    TPV_ST_TIME = 2'b01,
    TPV_ST_FIRE = 2'b11
  } tpv_state_t;

  // Register map (byte addresses)
  localparam logic [11:0] TPV_OFS_CTRL   = 12'h000;
  localparam logic [11:0] TPV_OFS_TGT0   = 12'h004;
  localparam logic [11:0] TPV_OFS_TGT1   = 12'h008;
  localparam logic [11:0] TPV_OFS_OPTIME = 12'h00c;
  localparam logic [11:0] TPV_OFS_TAPCFG = 12'h010;
  localparam logic [11:0] TPV_OFS_SCALE  = 12'h014;
  localparam logic [11:0] TPV_OFS_STATUS = 12'h018;
  localparam logic [11:0] TPV_OFS_VMEAS  = 12'h01c;

  // Field positions
  localparam int TPV_CTRL_SRC_LSB = 0;
  localparam int TPV_CTRL_GRP_BIT = 4;
  localparam int TPV_CTRL_EN_BIT  = 8;

  // Five position inputs, BCD units digit range
  localparam int          TPV_NPOS_IN  = 5;
  localparam logic [3:0]  TPV_BCD_MAX  = 4'h9;
  localparam logic [4:0]  TPV_BCD_TENS = 5'h0a;

  // Hysteresis: 3 percent of the threshold, as 3/100 in fixed point (x1024)
  localparam logic [15:0] TPV_HYST_NUM = 16'h001f;

  // Voltage update time base
  localparam int TPV_CLK_MHZ     = 250;
  localparam int TPV_TBASE_US    = 5000;
  localparam int TPV_TBASE_CYC   = TPV_TBASE_US * TPV_CLK_MHZ;

  // Reset values
  localparam logic [15:0] TPV_RST_TGT    = 16'h2710;
  localparam logic [15:0] TPV_RST_WIN    = 16'h0064;
  localparam logic [15:0] TPV_RST_OPTIME = 16'h003c;
  localparam logic [4:0]  TPV_RST_PMIN   = 5'h01;
  localparam logic [4:0]  TPV_RST_PMAX   = 5'h13;

  // Setting group: target, upper and lower offsets, in 0.01 percent units
  typedef struct packed {
    logic [15:0] target_voltage;
    logic [7:0]  win_up;
    logic [7:0]  win_dn;
  } tpv_group_t;

  // Tap decoder result
  typedef struct packed {
    logic [4:0] pos;
    logic       bad;
  } tpv_tap_t;

endpackage : tpv_pkg

/* tpv_tap_decode.sv */
// Tap position decoder for binary, BCD and scaled sources
module tpv_tap_decode
  import tpv_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Source and configuration
  input  wire tpv_src_t    src,
  input  wire logic [4:0]  din,
  input  wire logic [15:0] scaled_in,
  input  wire logic [15:0] scale_step,
  input  wire logic [4:0]  pos_min,
  input  wire logic [4:0]  pos_max,
  // Result
  output tpv_tap_t         tap
);

  typedef struct packed {
    tpv_tap_t tap;
  } tpv_dec_state_t;

  tpv_dec_state_t st_r;
  tpv_dec_state_t st_nxt;
  logic [15:0]    quot;
  logic [5:0]     sum;
  logic [4:0]     raw;
  logic           digit_bad;

  // Scaled position: divide by the span of one step, add the first position
  always_comb begin
    quot = (scale_step == 16'h0000) ? 16'h0000 : scaled_in / scale_step;
    sum = 6'(quot[4:0]) + 6'(pos_min);
    raw = 5'h00;
    digit_bad = 1'b0;
    unique case (src)
      TPV_SRC_BIN: begin
        raw = din;
      end
      TPV_SRC_BCD: begin
        raw = 5'(din[3:0]) + (din[4] ? TPV_BCD_TENS : 5'h00);
        digit_bad = (din[3:0] > TPV_BCD_MAX);
      end
      TPV_SRC_RES, TPV_SRC_DIVOLT: begin
        // Saturate so a runaway sensor or a high first position cannot wrap to a low tap
        raw = ((quot > 16'h001e) || sum[5]) ? 5'h1f : sum[4:0];
      end
    endcase
    st_nxt.tap.pos = raw;
    st_nxt.tap.bad = digit_bad || (raw < pos_min) || (raw > pos_max);
  end

  // Registered output
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tap = st_r.tap;

endmodule : tpv_tap_decode

/* tpv_top.sv */
// Tap position decode and first voltage window with APB register access
// Register map, one aligned 32-bit word per register, byte addresses
//   0x000 control
//         [1:0] position source, [4] setting group, [8] window enable
//   0x004 setting group 0
//         [31:16] target voltage, [15:8] upper offset, [7:0] lower offset
//   0x008 setting group 1, same layout as group 0
//   0x00c operating time, [15:0] in time base ticks
//   0x010 tap range
//         [4:0] lowest valid position, [12:8] highest valid position
//   0x014 scaled span of one tap step, [15:0]
//   0x018 status, read only
//         [31:16] operating timer, [9:8] window state, [7] low pick-up,
//         [6] high pick-up, [5] position invalid, [4:0] position
//   0x01c last sampled voltage, read only, [15:0]
//   Writes to other offsets are dropped, reads of them return zero
//   The bus never stalls and never signals an error
//
// Position source codes
//   0 binary contacts
//   1 decimal-coded contacts, units on the low four, ten on the fifth
//   2 scaled resistance value
//   3 scaled digital-input voltage value
//
// Port behaviour
//   Position contacts, scaled value and measurement are taken as synchronous
//   Raise and lower requests are single-cycle registered pulses
//   The invalid flag follows the contacts one clock later
//
// Voltage units
//   Target, offsets and measurement share one scale, 0.01 percent per count
//   Thresholds are one bit wider so the upper offset cannot wrap; a lower offset larger than the target still wraps
//
// Window pipeline, counted in time base ticks
//   Tick k      measurement sampled into the voltage register
//   Tick k+1    pick-up flags compared against the thresholds
//   Tick k+2    operating timer leaves the inside state
//   Tick k+n+2  timer reaches the operating time and arms the request
//   Tick k+n+3  one-cycle raise or lower pulse, then timing restarts
//   A request thus lags a departure by about the operating time plus three ticks
//   Between ticks the measurement input is ignored, so a glitch shorter than
//   one time base is only seen if it happens to straddle a tick
//
// Hazards and limitations
//   Hysteresis is 31/1024 of each threshold, a shade over three percent;
//   the power-of-two divisor saves a divider at the cost of that small error
//   With a window narrower than the hysteresis band a pick-up only releases
//   once the voltage has crossed back past the target
//   Clearing the enable drops a running timer and suppresses a pending pulse
//   A changed setting group acts on the next tick, with no timer restart
//   A zero tap step span forces the scaled position to the lowest position
//   The scaled position saturates at 31 rather than wrapping round
//
// Reset state
//   Both groups hold the nominal target with equal default offsets
//   Window disabled, binary source, group 0, default operating time
//   Tap range from the default lowest to the default highest position
//   Step span one count, so a raw scaled value reads as a position offset
//
// Integration notes
//   Window size and its split into halves are set by
//   software; the logic applies whatever offsets it is given unchecked
module tpv_top
  import tpv_pkg::*;
#(
  parameter int TBASE_CYC = TPV_TBASE_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Tap changer position contacts and scaled measurements
  input  wire logic [4:0]  tap_din,
  input  wire logic [15:0] tap_scaled,
  // Measured voltage, fundamental of selected phase-to-phase channel
  input  wire logic [15:0] volt_meas,
  // Control requests
  output logic             raise_req,
  output logic             lower_req,
  output logic             pos_invalid
);

  // Whole module state, one register copy per clock
  typedef struct packed {
    // Configuration written over the bus
    logic                    en;
    tpv_src_t                src;
    logic                    grp;
    tpv_group_t              g0;
    tpv_group_t              g1;
    logic [15:0]             optime;
    logic [4:0]              pmin;
    logic [4:0]              pmax;
    logic [15:0]             step;
    // Measurement and window timing
    logic [15:0]             vsamp;
    logic [31:0]             tb_cnt;
    logic [15:0]             op_cnt;
    tpv_state_t              state;
    logic                    up_pick;
    logic                    dn_pick;
    // Request pulses and bus read data
    logic                    raise;
    logic                    lower;
    logic [31:0]             rdata;
  } tpv_state_all_t;

  // Registered state and its next value
  tpv_state_all_t s_r;
  tpv_state_all_t s_nxt;
  // Decoded position and the settings of the selected group
  tpv_tap_t       tap;
  tpv_group_t     act;
  // Thresholds, release points and the widened sample
  logic [16:0]    thr_hi;
  logic [16:0]    thr_lo;
  logic [16:0]    hys_hi;
  logic [16:0]    hys_lo;
  logic [16:0]    v17;
  // Bus strobes, time base tick and window departure
  logic           wr;
  logic           rd;
  logic           tick;
  logic           outside;

  // Position decoder
  tpv_tap_decode u_dec (
    .clk       (clk),
    .rstn      (rstn),
    .src       (s_r.src),
    .din       (tap_din),
    .scaled_in (tap_scaled),
    .scale_step(s_r.step),
    .pos_min   (s_r.pmin),
    .pos_max   (s_r.pmax),
    .tap       (tap)
  );

  // Active group taken straight from the select bit, so a change lands at once
  assign act = s_r.grp ? s_r.g1 : s_r.g0;

  // Thresholds follow the target; hysteresis band is 3 percent of each threshold
  always_comb begin
    thr_hi = {1'b0, act.target_voltage} + 17'(act.win_up);
    thr_lo = {1'b0, act.target_voltage} - 17'(act.win_dn);
    hys_hi = thr_hi - 17'((27'(thr_hi) * 27'(TPV_HYST_NUM)) >> 10);
    hys_lo = thr_lo + 17'((27'(thr_lo) * 27'(TPV_HYST_NUM)) >> 10);
    v17    = {1'b0, s_r.vsamp};
  end

  // APB strobes; single-cycle access, no wait states
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign tick = (s_r.tb_cnt == 32'(TBASE_CYC - 1));
  assign outside = s_r.up_pick || s_r.dn_pick;

  // Next-state logic
  always_comb begin
    s_nxt = s_r;
    s_nxt.raise = 1'b0;
    s_nxt.lower = 1'b0;

    // Register writes
    if (wr) begin
      unique case (paddr)
        TPV_OFS_CTRL: begin
          s_nxt.src = tpv_src_t'(pwdata[TPV_CTRL_SRC_LSB +: 2]);
          s_nxt.grp = pwdata[TPV_CTRL_GRP_BIT];
          s_nxt.en  = pwdata[TPV_CTRL_EN_BIT];
        end
        TPV_OFS_TGT0:   s_nxt.g0 = pwdata;
        TPV_OFS_TGT1:   s_nxt.g1 = pwdata;
        TPV_OFS_OPTIME: s_nxt.optime = pwdata[15:0];
        TPV_OFS_TAPCFG: begin
          s_nxt.pmin = pwdata[4:0];
          s_nxt.pmax = pwdata[12:8];
        end
        TPV_OFS_SCALE:  s_nxt.step = pwdata[15:0];
        default: ;
      endcase
    end

    // Read data captured in setup so it is stable through the access phase
    if (rd) begin
      unique case (paddr)
        TPV_OFS_CTRL:   s_nxt.rdata = {23'h0, s_r.en, 3'h0, s_r.grp, 2'h0, s_r.src};
        TPV_OFS_TGT0:   s_nxt.rdata = s_r.g0;
        TPV_OFS_TGT1:   s_nxt.rdata = s_r.g1;
        TPV_OFS_OPTIME: s_nxt.rdata = {16'h0, s_r.optime};
        TPV_OFS_TAPCFG: s_nxt.rdata = {19'h0, s_r.pmax, 3'h0, s_r.pmin};
        TPV_OFS_SCALE:  s_nxt.rdata = {16'h0, s_r.step};
        TPV_OFS_STATUS: s_nxt.rdata = {s_r.op_cnt, 6'h0, s_r.state, s_r.dn_pick,
                                       s_r.up_pick, tap.bad, tap.pos};
        TPV_OFS_VMEAS:  s_nxt.rdata = {16'h0, s_r.vsamp};
        default:        s_nxt.rdata = 32'h0;
      endcase
    end

    // Time base: voltage is resampled and the window evaluated once per tick
    s_nxt.tb_cnt = tick ? 32'h0 : s_r.tb_cnt + 32'h1;
    if (tick) begin
      s_nxt.vsamp = volt_meas;

      // Pick-up sets beyond a threshold, releases only past the hysteresis band
      if (v17 > thr_hi) begin
        s_nxt.up_pick = 1'b1;
      end else if (v17 < hys_hi) begin
        s_nxt.up_pick = 1'b0;
      end
      if (v17 < thr_lo) begin
        s_nxt.dn_pick = 1'b1;
      end else if (v17 > hys_lo) begin
        s_nxt.dn_pick = 1'b0;
      end

      // Definite-time operating timer, counted in time base ticks
      unique case (s_r.state)
        TPV_ST_IN: begin
          s_nxt.op_cnt = 16'h0;
          if (outside && s_r.en) begin
            s_nxt.state = TPV_ST_TIME;
          end
        end
        TPV_ST_TIME: begin
          if (!outside || !s_r.en) begin
            s_nxt.state  = TPV_ST_IN;
            s_nxt.op_cnt = 16'h0;
          end else if (s_r.op_cnt + 16'h1 >= s_r.optime) begin
            s_nxt.state = TPV_ST_FIRE;
          end else begin
            s_nxt.op_cnt = s_r.op_cnt + 16'h1;
          end
        end
        TPV_ST_FIRE: begin
          // One request, then restart timing from zero for the next step
          s_nxt.raise  = s_r.dn_pick && s_r.en;
          s_nxt.lower  = s_r.up_pick && s_r.en;
          s_nxt.op_cnt = 16'h0;
          s_nxt.state  = TPV_ST_IN;
        end
        default: s_nxt.state = TPV_ST_IN;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_r        <= '0;
      s_r.g0     <= {TPV_RST_TGT, TPV_RST_WIN[7:0], TPV_RST_WIN[7:0]};
      s_r.g1     <= {TPV_RST_TGT, TPV_RST_WIN[7:0], TPV_RST_WIN[7:0]};
      s_r.optime <= TPV_RST_OPTIME;
      s_r.pmin   <= TPV_RST_PMIN;
      s_r.pmax   <= TPV_RST_PMAX;
      s_r.step   <= 16'h0001;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  assign prdata      = s_r.rdata;
  assign pready      = 1'b1;
  assign pslverr     = 1'b0;
  assign raise_req   = s_r.raise;
  assign lower_req   = s_r.lower;
  assign pos_invalid = tap.bad;

endmodule : tpv_top

/* tpv_top_asserts.sv */
// Port checker for the tap decode and voltage window block
module tpv_top_asserts
  import tpv_pkg::*;
#(
  parameter int TBASE_CYC = TPV_TBASE_CYC
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Field side
  input wire logic [4:0]  tap_din,
  input wire logic [15:0] tap_scaled,
  input wire logic [15:0] volt_meas,
  input wire logic        raise_req,
  input wire logic        lower_req,
  input wire logic        pos_invalid
);
  logic [31:0] gap_r;
  // Cycles since the last request; wide enough for the full time base, saturating
  always_ff @(posedge clk) begin
    if (!rstn || raise_req || lower_req) gap_r <= 32'h00000000;
    else if (gap_r != 32'hffffffff) gap_r <= gap_r + 32'h00000001;
  end
  a_req_exclusive: assert property (@(posedge clk) disable iff (!rstn)
    !(raise_req && lower_req)) else $error("raise and lower at once");
  a_lower_pulse: assert property (@(posedge clk) disable iff (!rstn)
    lower_req |=> !lower_req) else $error("lower request longer than one cycle");
  a_raise_pulse: assert property (@(posedge clk) disable iff (!rstn)
    raise_req |=> !raise_req) else $error("raise request longer than one cycle");
  a_req_spacing: assert property (@(posedge clk) disable iff (!rstn)
    (raise_req || lower_req) |-> gap_r >= TBASE_CYC - 1) else $error("requests too close");
  a_reset_quiet: assert property (@(posedge clk)
    !rstn |=> !raise_req && !lower_req && !pos_invalid && prdata == 32'h0)
    else $error("outputs not cleared by reset");
  a_prdata_hold: assert property (@(posedge clk) disable iff (!rstn)
    !psel |=> $stable(prdata)) else $error("read data moved while idle");
  a_ready_high: assert property (@(posedge clk) disable iff (!rstn)
    psel && penable |-> pready) else $error("wait state inserted");
  a_no_error: assert property (@(posedge clk) disable iff (!rstn)
    psel && penable |-> !pslverr) else $error("slave error raised");
endmodule : tpv_top_asserts

bind tpv_top tpv_top_asserts #(.TBASE_CYC(TBASE_CYC)) tpv_top_asserts_inst (
  .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tap_din(tap_din), .tap_scaled(tap_scaled), .volt_meas(volt_meas),
  .raise_req(raise_req), .lower_req(lower_req), .pos_invalid(pos_invalid));

/* tpv_tap_model.sv */
// Model of the tap changer contacts, stepping on raise and lower pulses
module tpv_tap_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Control pulses
  input  wire logic       raise_req,
  input  wire logic       lower_req,
  // Bench loads a contact pattern, illegal ones too
  input  wire logic       ld,
  input  wire logic [4:0] ld_val,
  // Contacts and position
  output logic [4:0]      tap_din,
  output logic [4:0]      pos
);
  // One step per pulse; no end stop, so a double pulse shows up
  always_ff @(posedge clk) begin
    if (!rstn) pos <= 5'h00;
    else if (ld) pos <= ld_val;
    else if (raise_req) pos <= pos + 5'h01;
    else if (lower_req) pos <= pos - 5'h01;
  end
  assign tap_din = pos;
endmodule : tpv_tap_model

/* test_tpv_top.sv */
// Testbench for the tap decode and voltage window block
module test_tpv_top;
  import tpv_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TB = 10;
  typedef struct packed {
    tpv_src_t src; logic [4:0] din; logic [15:0] sc; logic [12:0] cfg; logic [5:0] exp; logic cp;
  } tpv_row_t;
  logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, ld = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, raise_req, lower_req, pos_invalid;
  logic [4:0]  ld_val = 5'h00, tap_din, mpos;
  logic [15:0] tap_scaled = 16'h0000, volt_meas = 16'h2710;
  int          error_cnt = 0, tests_run = 0, n;
  // Decoder cases: source, contacts, scaled value, range, {bad,pos}, position checked
  tpv_row_t rows[15] = '{
    '{TPV_SRC_BIN, 5'h00, 16'h0, 13'h1f00, 6'h00, 1'b1}, '{TPV_SRC_BIN, 5'h01, 16'h0, 13'h1f00, 6'h01, 1'b1},
    '{TPV_SRC_BIN, 5'h10, 16'h0, 13'h1f00, 6'h10, 1'b1}, '{TPV_SRC_BIN, 5'h1f, 16'h0, 13'h1f00, 6'h1f, 1'b1},
    '{TPV_SRC_BIN, 5'h00, 16'h0, 13'h1301, 6'h20, 1'b1}, '{TPV_SRC_BIN, 5'h14, 16'h0, 13'h1301, 6'h34, 1'b1},
    '{TPV_SRC_BCD, 5'h09, 16'h0, 13'h1301, 6'h09, 1'b1}, '{TPV_SRC_BCD, 5'h10, 16'h0, 13'h1301, 6'h0a, 1'b1},
    '{TPV_SRC_BCD, 5'h18, 16'h0, 13'h1301, 6'h12, 1'b1}, '{TPV_SRC_BCD, 5'h0a, 16'h0, 13'h1301, 6'h20, 1'b0},
    '{TPV_SRC_RES, 5'h00, 16'h0, 13'h1301, 6'h01, 1'b1}, '{TPV_SRC_RES, 5'h00, 16'hb4, 13'h1301, 6'h13, 1'b1},
    '{TPV_SRC_RES, 5'h00, 16'h5a, 13'h1301, 6'h0a, 1'b1}, '{TPV_SRC_DIVOLT, 5'h00, 16'hb4, 13'h1301, 6'h13, 1'b1},
    '{TPV_SRC_RES, 5'h00, 16'h12c, 13'h1f02, 6'h1f, 1'b1}};
  logic [11:0] ra[5] = '{TPV_OFS_TGT0, TPV_OFS_OPTIME, TPV_OFS_TAPCFG, TPV_OFS_SCALE, 12'h020};
  logic [31:0] rv[5] = '{32'h27106464, 32'h3c, 32'h1301, 32'h1, 32'h0};
  logic [15:0] hv[3] = '{16'h28a0, 16'h2774, 16'h26ac};
  logic [15:0] ov[2] = '{16'h2580, 16'h28a0};
  logic [15:0] bv[2] = '{16'h2774, 16'h26ac};
  tpv_top #(.TBASE_CYC(TB)) tpv_top_inst (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tap_din(tap_din), .tap_scaled(tap_scaled),
    .volt_meas(volt_meas), .raise_req(raise_req), .lower_req(lower_req),
    .pos_invalid(pos_invalid));
  tpv_tap_model tpv_tap_model_inst (.clk(clk), .rstn(rstn), .raise_req(raise_req),
    .lower_req(lower_req), .ld(ld), .ld_val(ld_val), .tap_din(tap_din), .pos(mpos));
  always #2 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; waits for pready, takes read data at that edge
  // Only the watchdog ends a stalled wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic final_report;
    $display("errors %0d of %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  // Watchdog at several times the expected run of about a thousand cycles
  initial begin
    #20000;
    error_cnt++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b1, 12'h020, 32'hffffffff);
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, rv[i]);
    end
    apb(1'b1, TPV_OFS_SCALE, 32'h0000000a);
    foreach (rows[i]) begin
      apb(1'b1, TPV_OFS_CTRL, {30'h0, rows[i].src});
      apb(1'b1, TPV_OFS_TAPCFG, {19'h0, rows[i].cfg});
      ld <= 1'b1; ld_val <= rows[i].din; tap_scaled <= rows[i].sc;
      @(posedge clk);
      ld <= 1'b0;
      repeat (3) @(posedge clk);
      apb(1'b0, TPV_OFS_STATUS, 32'h0);
      chk(32'(rd[5]), 32'(rows[i].exp[5]));
      chk(32'(pos_invalid), 32'(rows[i].exp[5]));
      if (rows[i].cp) chk(32'(rd[4:0]), 32'(rows[i].exp[4:0]));
    end
    // Equal halves of a window wider than a tap step
    apb(1'b1, TPV_OFS_TGT0, 32'h2710ffff);
    apb(1'b1, TPV_OFS_TGT1, 32'h2900ffff);
    apb(1'b1, TPV_OFS_CTRL, 32'h00000100);
    for (int i = 0; i < 3; i++) begin
      volt_meas <= hv[i];
      repeat (4 * TB) @(posedge clk);
      apb(1'b0, TPV_OFS_STATUS, 32'h0);
      chk(32'(rd[6]), 32'(i < 2));
      if (i == 0) chk(32'(rd[9:8]), 32'(TPV_ST_TIME));
    end
    chk({rd[31:16], 6'h0, rd[9:8], 8'h0}, {16'h0, 6'h0, TPV_ST_IN, 8'h0});
    // Start the contact model mid-range so both step directions show
    ld <= 1'b1; ld_val <= 5'h0a;
    @(posedge clk);
    ld <= 1'b0;
    apb(1'b1, TPV_OFS_OPTIME, 32'h00000003);
    for (int i = 0; i < 2; i++) begin
      volt_meas <= ov[i];
      n = 0;
      do begin @(posedge clk); n++; end while (raise_req !== 1'b1 && lower_req !== 1'b1 && n < 400);
      chk(32'(raise_req), 32'(i == 0));
      chk(32'(lower_req), 32'(i == 1));
      chk(32'(n >= 3 * TB), 32'h1);
      volt_meas <= bv[i];
      repeat (10 * TB) @(posedge clk);
      chk(32'(mpos), 32'(i == 0 ? 5'h0b : 5'h0a));
    end
    // Same voltage lies inside group 1 but above group 0; park inside both first
    volt_meas <= 16'h280a;
    repeat (2 * TB) @(posedge clk);
    apb(1'b1, TPV_OFS_CTRL, 32'h00000110);
    volt_meas <= 16'h28a0;
    repeat (4 * TB) @(posedge clk);
    apb(1'b0, TPV_OFS_STATUS, 32'h0);
    chk(32'(rd[7:6]), 32'h0);
    apb(1'b1, TPV_OFS_CTRL, 32'h00000100);
    repeat (4 * TB) @(posedge clk);
    apb(1'b0, TPV_OFS_STATUS, 32'h0);
    chk(32'(rd[7:6]), 32'h1);
    // Reset in mid-run brings settings and outputs back to their reset values
    volt_meas <= 16'h2710;
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'({raise_req, lower_req, pos_invalid}), 32'h0);
    chk(prdata, 32'h0);
    rstn <= 1'b1;
    apb(1'b0, TPV_OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, TPV_OFS_TGT0, 32'h0);
    chk(rd, {TPV_RST_TGT, TPV_RST_WIN[7:0], TPV_RST_WIN[7:0]});
    apb(1'b0, TPV_OFS_STATUS, 32'h0);
    chk(rd, 32'h00000020);
    final_report();
  end
endmodule : test_tpv_top
